/* File: core/cpu_timing_cfg.svh */
// Purpose: Timing constants for the machine-timing and loop-control block
// Assumes: mclk runs at 40 MHz; the timing source is a 10 MHz oscillator
// Notes:   Cycle counts are derived from the times, never typed directly
`ifndef CPU_TIMING_CFG_SVH
`define CPU_TIMING_CFG_SVH

// Clock and oscillator rates
`define TLC_MCLK_PERIOD_NS 25
`define TLC_OSC_FREQ_MHZ 10

// Oscillator half period in ns and in mclk cycles (50 ns -> 2 cycles)
`define TLC_OSC_HALF_NS (1000 / (2 * `TLC_OSC_FREQ_MHZ))
`define TLC_OSC_HALF_CYC (`TLC_OSC_HALF_NS / `TLC_MCLK_PERIOD_NS)

// Phase clock pulse width limits; least time rounds up, longest rounds down
`define TLC_PH_PULSE_MIN_NS 45
`define TLC_PH_PULSE_MAX_NS 55
`define TLC_PH_PULSE_MIN_CYC \
    ((`TLC_PH_PULSE_MIN_NS + `TLC_MCLK_PERIOD_NS - 1) / `TLC_MCLK_PERIOD_NS)
`define TLC_PH_PULSE_MAX_CYC (`TLC_PH_PULSE_MAX_NS / `TLC_MCLK_PERIOD_NS)

// Time state and machine cycle
`define TLC_TIME_STATE_NS 200
`define TLC_TIME_STATE_CYC (`TLC_TIME_STATE_NS / `TLC_MCLK_PERIOD_NS)
`define TLC_CYCLE_NS 1600
`define TLC_CYCLE_CYC (`TLC_CYCLE_NS / `TLC_MCLK_PERIOD_NS)

// Strobe-enable low pulse while instruction loop is selected
`define TLC_SEN_LOW_NS 400
`define TLC_SEN_LOW_CYC (`TLC_SEN_LOW_NS / `TLC_MCLK_PERIOD_NS)

// Ring positions of interest and reset values
`define TLC_STATE_FIRST 3'h0
`define TLC_STATE_LAST_SET 3'h6
`define TLC_STATE_FINAL 3'h7
`define TLC_SUB_FINAL 2'h3
`define TLC_RST_RING 3'h7
`define TLC_RST_SUB 2'h3

`endif

/* File: core/cpu_timing_pkg.sv */
// Purpose: Types shared by the machine-timing block and its input filter
// Assumes: Constants live in cpu_timing_cfg.svh
// Notes:   One packed struct per module holds its state, bar the check counters
package cpu_timing_pkg;

    typedef enum logic [1:0] {
        PH_FETCH,
        PH_INDIRECT,
        PH_EXECUTE,
        PH_INTERRUPT
    } machine_phase_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } filt_state_t;

    typedef struct packed {
        logic [1:0] half_cnt;
        logic osc;
        logic [1:0] sub;
        logic [2:0] ring;
        logic phase_ff1;
        logic phase_ff2;
        logic strobe;
        logic strobe_aux;
        logic rc1;
        logic rc2;
        logic last_state;
        logic phase_clk;
        machine_phase_t phase;
        logic step;
        logic sen_n;
    } timing_state_t;

endpackage

/* File: core/switch_filter.sv */
// Purpose: Three-flop synchroniser and agreement filter for a panel switch
// Assumes: The switch level is static and asynchronous to mclk
// Notes:   The first flop feeds only the second, so metastability stays put
`timescale 1ns/1ps
`include "cpu_timing_cfg.svh"

module switch_filter
    import cpu_timing_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic raw,
    output logic level
);

    filt_state_t st_q;
    filt_state_t st_d;

    // Shift the level in; accept a change once flops two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
        end
    end

    // Synchronous reset to a known deasserted level
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.level;

endmodule

/* File: core/cpu_timing_loop_control.sv */
// Purpose: Machine-timing generator with phase and instruction loop controls
// Assumes: mclk at 40 MHz stands for the 10 MHz crystal source; switches static
// Notes:   All outputs are flops; a 1.6 us cycle is 64 mclk cycles
`timescale 1ns/1ps
`include "cpu_timing_cfg.svh"

module cpu_timing_loop_control
    import cpu_timing_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic phase_normal_select,
    input wire logic instruction_loop_select,
    input wire logic step_request,
    input wire machine_phase_t next_phase,
    output logic clock_phase_ff_first,
    output logic clock_phase_ff_second,
    output logic time_strobe,
    output logic time_strobe_aux,
    output logic ring_clock_first,
    output logic ring_clock_second,
    output logic [2:0] time_state,
    output logic last_time_state_ff,
    output logic phase_clock,
    output machine_phase_t machine_phase,
    output logic register_step_strobe,
    output logic strobe_enable_n
);

    localparam logic [1:0] HALF_LAST = 2'(`TLC_OSC_HALF_CYC - 1);
    localparam int CYCLE_CYC = `TLC_CYCLE_CYC;
    localparam int STATE_CYC = `TLC_TIME_STATE_CYC;

    timing_state_t st_q;
    timing_state_t st_d;
    logic normal_f;
    logic iloop_f;
    logic osc_edge;
    logic ring_adv;

    // Panel switches are asynchronous, so both pass the agreement filter
    switch_filter u_normal_filter (
        .mclk(mclk),
        .nrst(nrst),
        .raw(phase_normal_select),
        .level(normal_f)
    );

    switch_filter u_iloop_filter (
        .mclk(mclk),
        .nrst(nrst),
        .raw(instruction_loop_select),
        .level(iloop_f)
    );

    // Each oscillator half period ends on osc_edge; four halves make a time state
    assign osc_edge = (st_q.half_cnt == HALF_LAST);
    assign ring_adv = osc_edge && (st_q.sub == `TLC_SUB_FINAL);

    // Next state: divider, phase flops, gates, ring and loop controls
    always_comb begin
        st_d = st_q;
        st_d.half_cnt = osc_edge ? 2'h0 : st_q.half_cnt + 2'h1;
        if (osc_edge) begin
            st_d.osc = ~st_q.osc;
            st_d.sub = st_q.sub + 2'h1;
        end
        if (ring_adv) begin
            st_d.ring = st_q.ring + 3'h1;
        end
        // Quadrature pair: first high in sub 0-1, second high in sub 1-2
        st_d.phase_ff1 = (st_d.sub == 2'h0) || (st_d.sub == 2'h1);
        st_d.phase_ff2 = (st_d.sub == 2'h1) || (st_d.sub == 2'h2);
        // Separate gates on the first flop; a shared fault shows on both
        st_d.strobe = st_d.phase_ff1 & ~st_d.phase_ff2;
        st_d.strobe_aux = st_d.phase_ff1 & st_d.phase_ff2;
        // Shared gating on the second flop; rc1 ends where the ring steps
        st_d.rc2 = st_d.phase_ff2 & ~st_d.phase_ff1;
        st_d.rc1 = ~st_d.phase_ff2 & ~st_d.phase_ff1;
        // Last time state flop sets at entry to state 6 and clears at entry to 0
        if (ring_adv && st_q.ring == (`TLC_STATE_LAST_SET - 3'h1)) begin
            st_d.last_state = 1'b1;
        end else if (ring_adv && st_q.ring == `TLC_STATE_FINAL) begin
            st_d.last_state = 1'b0;
        end
        // One half-period pulse at the start of each cycle unless phase loop is selected
        st_d.phase_clk = st_d.strobe && (st_d.ring == `TLC_STATE_FIRST) && normal_f;
        // Phase flops move only on the phase clock pulse
        if (st_q.phase_clk) begin
            st_d.phase = next_phase;
        end
        // Step strobe in state 6 when asked, unless instruction loop holds it
        st_d.step = st_d.strobe && (st_d.ring == `TLC_STATE_LAST_SET) && step_request
                    && !iloop_f;
        // Low across states 6 and 7, i.e. 400 ns, only while looping
        st_d.sen_n = ~(iloop_f && (st_d.ring[2:1] == 2'b11));
    end

    // Reset parks the ring at the last state so the first step enters state 0
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_q <= '{half_cnt: 2'h0, osc: 1'b0, sub: `TLC_RST_SUB,
                      ring: `TLC_RST_RING, phase_ff1: 1'b0, phase_ff2: 1'b0, strobe: 1'b0,
                      strobe_aux: 1'b0, rc1: 1'b1, rc2: 1'b0, last_state: 1'b1,
                      phase_clk: 1'b0, phase: PH_FETCH, step: 1'b0,
                      sen_n: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flops
    assign clock_phase_ff_first = st_q.phase_ff1;
    assign clock_phase_ff_second = st_q.phase_ff2;
    assign time_strobe = st_q.strobe;
    assign time_strobe_aux = st_q.strobe_aux;
    assign ring_clock_first = st_q.rc1;
    assign ring_clock_second = st_q.rc2;
    assign time_state = st_q.ring;
    assign last_time_state_ff = st_q.last_state;
    assign phase_clock = st_q.phase_clk;
    assign machine_phase = st_q.phase;
    assign register_step_strobe = st_q.step;
    assign strobe_enable_n = st_q.sen_n;

    // Helper counters that only the checks below read
    logic [3:0] ph_hi_cnt;
    logic [5:0] sen_lo_cnt;
    logic [5:0] iloop_steady_cnt;
    logic iloop_prev;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ph_hi_cnt <= 4'h0;
            sen_lo_cnt <= 6'h00;
            iloop_steady_cnt <= 6'h00;
            iloop_prev <= 1'b0;
        end else begin
            ph_hi_cnt <= phase_clock ? ph_hi_cnt + 4'h1 : 4'h0;
            sen_lo_cnt <= strobe_enable_n ? 6'h00 : sen_lo_cnt + 6'h01;
            iloop_prev <= iloop_f;
            if (iloop_f != iloop_prev) begin
                iloop_steady_cnt <= 6'h00;
            end else if (iloop_steady_cnt != 6'h3F) begin
                iloop_steady_cnt <= iloop_steady_cnt + 6'h01;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_last_state_six;
        (time_state == 3'h6) && last_time_state_ff;
    endsequence

    sequence s_last_state_seven;
        (time_state == 3'h7) && last_time_state_ff;
    endsequence

    a_osc_half_period: assert property (
        $changed(st_q.osc) |=> $stable(st_q.osc) ##1 $changed(st_q.osc))
        else $error("oscillator half period is not two clocks");

    a_phase_pulse_width: assert property (
        $fell(phase_clock) && normal_f && $past(normal_f, 3) |->
            ph_hi_cnt >= `TLC_PH_PULSE_MIN_CYC && ph_hi_cnt <= `TLC_PH_PULSE_MAX_CYC)
        else $error("phase clock pulse width out of range");

    a_phase_loop_low: assert property (
        !normal_f |=> !phase_clock)
        else $error("phase clock pulsed while phase loop selected");

    a_step_blocked: assert property (
        iloop_f |=> !register_step_strobe)
        else $error("step strobe issued during instruction loop");

    a_step_normal: assert property (
        $rose(time_strobe) && time_state == 3'h6 && $past(step_request) && !$past(iloop_f)
            |-> register_step_strobe)
        else $error("step strobe missing in normal mode");

    a_sen_low_width: assert property (
        $rose(strobe_enable_n) && iloop_steady_cnt > 6'h14 |->
            sen_lo_cnt == 6'(`TLC_SEN_LOW_CYC))
        else $error("strobe enable low pulse is not 400 ns");

    a_sen_idle_high: assert property (
        !iloop_f |=> strobe_enable_n)
        else $error("strobe enable low without instruction loop");

    a_strobe_source: assert property (
        (time_strobe || time_strobe_aux) |-> clock_phase_ff_first)
        else $error("time strobe without first phase flop");

    a_ring_clock_source: assert property (
        (ring_clock_first |-> !clock_phase_ff_second && !clock_phase_ff_first)
        and (ring_clock_second |-> clock_phase_ff_second))
        else $error("ring clock not from second phase flop");

    a_phase_hold: assert property (
        !phase_clock |=> $stable(machine_phase))
        else $error("machine phase moved without phase clock");

    a_last_state_span: assert property (
        $rose(last_time_state_ff) |-> s_last_state_six ##STATE_CYC s_last_state_seven
            ##STATE_CYC (time_state == 3'h0 && !last_time_state_ff))
        else $error("last time state flop not set 1.2 us to 1.6 us");

    a_cycle_length: assert property (
        $rose(time_strobe) && time_state == 3'h0 |->
            ##CYCLE_CYC (time_strobe && time_state == 3'h0 && $rose(time_strobe)))
        else $error("machine cycle is not 1.6 us");

endmodule

/* File: sim/panel_switch_model.sv */
// Purpose: Front-panel slide switch pair seen by the timing block
// Assumes: Levels move asynchronously to mclk
// Notes:   A commanded bounce flips phase select for 20 ns only
`timescale 1ns/1ps
module panel_switch_model (
    input wire logic want_normal,
    input wire logic want_loop,
    input wire logic glitch,
    output logic phase_normal_select,
    output logic instruction_loop_select
);
    logic blip = 1'b0;
    // Contacts settle 7 ns after the command, never on a clock edge;
    // continuous drive keeps the levels defined from 7 ns on
    assign #7 phase_normal_select = want_normal ^ blip;
    assign #7 instruction_loop_select = want_loop;
    // Bounce kept under one clock, so the filter has to reject it
    always @(posedge glitch) begin
        blip = 1'b1;
        #20 blip = 1'b0;
    end
endmodule

/* File: sim/cpu_timing_loop_control_test.sv */
// Purpose: Self-checking bench for the machine-timing and loop-control block
// Assumes: Inputs move on the falling edge; outputs are sampled there
// Notes:   Each machine cycle a scenario checks is compared slot by slot over 64 clocks
`timescale 1ns/1ps
module cpu_timing_loop_control_test;
    import cpu_timing_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic want_normal = 1'b1;
    logic want_loop = 1'b0;
    logic glitch = 1'b0;
    logic step_request = 1'b0;
    machine_phase_t next_phase = PH_FETCH;
    machine_phase_t held = PH_FETCH;
    logic sel_normal, sel_iloop, phase_ff1, phase_ff2, strobe, strobe_aux;
    logic rc1, rc2, last_ff, ph_clk, step, sen_n;
    logic [2:0] time_state;
    machine_phase_t machine_phase;
    int fails = 0;
    int comparisons = 0;

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    panel_switch_model panel_switch_model_i (.want_normal(want_normal),
        .want_loop(want_loop), .glitch(glitch), .phase_normal_select(sel_normal),
        .instruction_loop_select(sel_iloop));

    cpu_timing_loop_control cpu_timing_loop_control_i (.mclk(mclk), .nrst(nrst),
        .phase_normal_select(sel_normal), .instruction_loop_select(sel_iloop),
        .step_request(step_request), .next_phase(next_phase),
        .clock_phase_ff_first(phase_ff1), .clock_phase_ff_second(phase_ff2),
        .time_strobe(strobe), .time_strobe_aux(strobe_aux), .ring_clock_first(rc1),
        .ring_clock_second(rc2), .time_state(time_state),
        .last_time_state_ff(last_ff), .phase_clock(ph_clk),
        .machine_phase(machine_phase), .register_step_strobe(step),
        .strobe_enable_n(sen_n));

    task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset is held ten clocks; the ring parks in its last state meanwhile
    task automatic do_reset();
        nrst = 1'b0;
        next_phase = PH_FETCH;
        held = PH_FETCH;
        repeat (10) @(negedge mclk);
        chk("rst_ring", 3'h7, time_state);
        chk("rst_rc1", 3'h1, rc1);
        chk("rst_sen_n", 3'h1, sen_n);
        chk("rst_phase", PH_FETCH, machine_phase);
        nrst = 1'b1;
    endtask

    // Switch filter needs a few clocks; 80 covers a whole cycle as well
    task automatic settle(input logic n, input logic l, input logic r);
        want_normal = n;
        want_loop = l;
        step_request = r;
        repeat (80) @(negedge mclk);
    endtask

    // Align on the entry to state 0, then compare all 64 slots
    task automatic cycle(input logic n, input logic l, input logic r, input machine_phase_t p);
        logic [2:0] prev;
        logic hit;
        int s;
        hit = 1'b0;
        for (int g = 0; g < 200 && !hit; g++) begin
            prev = time_state;
            @(negedge mclk);
            hit = (prev === 3'h7 && time_state === 3'h0);
        end
        // New phase only now, so skipped cycles keep loading the held one
        next_phase = p;
        chk("align", 3'h1, hit);
        for (int k = 0; k < 64; k++) begin
            s = k % 8;
            chk("time_state", 3'(k / 8), time_state);
            chk("last_ff", k >= 48, last_ff);
            chk("time_strobe", s < 2, strobe);
            chk("time_strobe_aux", s == 2 || s == 3, strobe_aux);
            chk("clock_phase_ff_first", s < 4, phase_ff1);
            chk("clock_phase_ff_second", s >= 2 && s < 6, phase_ff2);
            chk("rc2", s == 4 || s == 5, rc2);
            chk("rc1", s >= 6, rc1);
            chk("phase_clock", n && k < 2, ph_clk);
            chk("step", r && !l && (k == 48 || k == 49), step);
            chk("sen_n", !(l && k >= 48), sen_n);
            chk("phase", (k > 0 && n) ? p : held, machine_phase);
            @(negedge mclk);
        end
        if (n) begin
            held = p;
        end
    endtask

    task automatic sc_normal();
        settle(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cycle(1'b1, 1'b0, 1'b1, machine_phase_t'(i));
        end
    endtask

    task automatic sc_no_request();
        settle(1'b1, 1'b0, 1'b0);
        cycle(1'b1, 1'b0, 1'b0, PH_INDIRECT);
    endtask

    task automatic sc_instr_loop();
        settle(1'b1, 1'b1, 1'b1);
        cycle(1'b1, 1'b1, 1'b1, PH_EXECUTE);
        cycle(1'b1, 1'b1, 1'b1, PH_FETCH);
    endtask

    // Bounce lands three clocks before the phase pulse, where an unfiltered
    // path would blank it; the filter must reject it
    task automatic sc_bounce();
        settle(1'b1, 1'b0, 1'b1);
        while (!(time_state === 3'h7 && rc2 === 1'b1)) begin
            @(negedge mclk);
        end
        glitch = 1'b1;
        cycle(1'b1, 1'b0, 1'b1, PH_INTERRUPT);
        glitch = 1'b0;
    endtask

    task automatic sc_phase_loop();
        settle(1'b0, 1'b0, 1'b1);
        cycle(1'b0, 1'b0, 1'b1, PH_INDIRECT);
        cycle(1'b0, 1'b0, 1'b1, PH_EXECUTE);
    endtask

    // Second reset in mid-run, then normal timing must resume
    task automatic sc_mid_reset();
        do_reset();
        settle(1'b1, 1'b0, 1'b1);
        cycle(1'b1, 1'b0, 1'b1, PH_EXECUTE);
    endtask

    initial begin
        do_reset();
        sc_normal();
        sc_no_request();
        sc_instr_loop();
        sc_bounce();
        sc_phase_loop();
        sc_mid_reset();
        conclude();
    end

    // Whole run is near 1800 clocks; this limit leaves a wide margin
    initial begin
        #500000;
        fails++;
        $display("[FAIL] watchdog expected finish seen hang");
        conclude();
    end
endmodule
